// file: design/slls_top.sv
/*
 * Receive-side configuration and lane alignment of a quad converter with
 * one or two serial links: power-down mapping, dual B clock gating, CDR
 * mode decode, subclass handling, multiframe counter and lane release.
 * Assumes clk_sys_i is the lane word clock (lane rate / 40) and every lane
 * delivers one deserialised word per clock, synchronous to it.
 */
// How it works
// R01 - Software sets power-down mask 0111, 0110 or 0011 from converter count and mode
// R02 - With all four converters used, software writes the power-down mask as zero
// R03 - Swap bit set in dual link with one converter routes dual B to output 3
// R04 - Dual B clock gated by 1 in bits 7:6 only when converters 2, 3 down
// R05 - CDR mode decoded from half-rate, oversample and PLL divider fields
// R06 - Software picks equalizer mode 1 below 12 dB loss, mode 0 up to 17.5 dB
// R07 - Both subclasses supported; subclass 1 aligns to external SYSREF
// R08 - Subclass 0 ignores SYSREF and uses the internal multiframe counter
// R09 - Subclass 0 still releases all lanes within one multiframe cycle
// R10 - All delays are counted in lane word clock cycles
// R11 - Frames per word is four divided by octets per frame
// R12 - Words per multiframe is K over frames per word; K 16 barred at factor 4
// R13 - Delay and variation settings release every lane on one boundary
// R14 - Software derives min and max delay from fixed and variable delays
// R15 - Software sets variation as max plus one minus min minus one
// R16 - Variation settings above ten are refused and block alignment
// R17 - Subclass 1 delay setting is in frame clocks, converted here to words
// R18 - Subclass 0 delay setting is in word clocks within the multiframe
// R19 - Software programs identical settings into every link and device
// R20 - Dual link splits lanes into two links, each with its own reset
// R21 - Lanes buffer data and release at the delayed multiframe boundary
`include "slls_params.svh"

module slls_top #(
    parameter int NUM_LANES = 8,
    parameter int DATA_W = 32,
    parameter int BUF_DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [11:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Static configuration
    input wire logic [3:0] converter_powerdown_mask_i,
    input wire logic iq_route_swap_i,
    input wire logic two_link_select_i,
    input wire logic half_rate_i,
    input wire logic cdr_oversample_i,
    input wire logic [1:0] serdes_pll_divider_i,
    input wire logic equalizer_mode_i,
    input wire logic subclass_i,
    input wire logic [2:0] octets_per_frame_i,
    input wire logic k_is_32_i,
    input wire logic [4:0] multiframe_delay_i,
    input wire logic [3:0] multiframe_variation_i,
    input wire logic [1:0] link_reset_i,
    input wire logic [NUM_LANES-1:0] lane_enable_i,
    // Board timing
    input wire logic sysref_i,
    // Lane data in and out
    input wire logic [NUM_LANES-1:0] lane_valid_i,
    input wire logic [NUM_LANES*DATA_W-1:0] lane_data_i,
    output logic [NUM_LANES-1:0] lane_ready_o,
    output logic [NUM_LANES-1:0] lane_out_valid_o,
    output logic [NUM_LANES*DATA_W-1:0] lane_data_o,
    // Analog side controls and status
    output logic [3:0] converter_powerdown_o,
    output logic dual_b_clock_gate_o,
    output logic route_dual_b_to_out3_o,
    output logic equalizer_low_power_o,
    output slls_pkg::slls_cdr_mode_t cdr_mode_o,
    output logic [2:0] frames_per_word_factor_o,
    output logic [5:0] words_per_multiframe_o,
    output logic lmfc_boundary_o,
    output logic config_error_o,
    output logic window_error_o,
    output logic aligned_o
);

    localparam int PW = $clog2(BUF_DEPTH);
    if (NUM_LANES < 2 || NUM_LANES % 2 != 0 || BUF_DEPTH <= 10 || (1 << PW) != BUF_DEPTH) begin : g_bad_cfg
        $error("slls_top: lane count must be even, buffer depth a power of two above ten");
    end
    // Register state
    logic [7:0] dual_b_clock_power_reg, dual_b_clock_power_next;
    logic [4:0] lmfc_cnt_reg, lmfc_cnt_next;
    logic sysref_prev_reg, sysref_prev_next;
    logic window_err_reg, window_err_next;
    slls_pkg::slls_align_state_t state_reg, state_next;

    logic [2:0] fpw;
    logic [1:0] fpw_shift;
    logic [5:0] k_val, wpm;
    logic [4:0] release_word;
    logic cfg_bad, at_release, sysref_edge;
    logic [NUM_LANES-1:0] lane_active, lane_has_data, lane_over;
    logic all_arrived, any_over, run_en;
    // Dual B clock power register; other bits just store
    always_comb begin
        dual_b_clock_power_next = dual_b_clock_power_reg;
        if (reg_wr_i && reg_addr_i == `SLLS_REG_DUAL_B_CLOCK_POWER) begin
            dual_b_clock_power_next = reg_wdata_i;
        end
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dual_b_clock_power_reg <= `SLLS_REG_DUAL_B_RESET;
        end else begin
            dual_b_clock_power_reg <= dual_b_clock_power_next;
        end
    end
    assign reg_rdata_o = (reg_addr_i == `SLLS_REG_DUAL_B_CLOCK_POWER) ? dual_b_clock_power_reg : 8'h00;
    // Gate only when both dual B converters are down, else the clock would starve live outputs
    assign dual_b_clock_gate_o = (dual_b_clock_power_reg[`SLLS_GATE_MSB:`SLLS_GATE_LSB] == `SLLS_GATE_ON)
                                 && (converter_powerdown_mask_i[3:2] == `SLLS_DUAL_B_DOWN); // R04
    assign converter_powerdown_o = converter_powerdown_mask_i; // R01
    assign route_dual_b_to_out3_o = iq_route_swap_i && two_link_select_i; // R03
    assign equalizer_low_power_o = equalizer_mode_i;
    always_comb begin
        case ({half_rate_i, cdr_oversample_i, serdes_pll_divider_i}) // R05
            4'h6: cdr_mode_o = slls_pkg::SLLS_CDR_OVERSAMPLE;
            4'h1: cdr_mode_o = slls_pkg::SLLS_CDR_FULL_RATE;
            4'h8: cdr_mode_o = slls_pkg::SLLS_CDR_HALF_RATE;
            default: cdr_mode_o = slls_pkg::SLLS_CDR_INVALID;
        endcase
    end

    // Frame and multiframe arithmetic in word clocks
    always_comb begin
        case (octets_per_frame_i) // R11
            `SLLS_F_ONE: begin
                fpw = `SLLS_FPW_FOUR;
                fpw_shift = `SLLS_SHIFT_FPW4;
            end
            `SLLS_F_TWO: begin
                fpw = `SLLS_FPW_TWO;
                fpw_shift = `SLLS_SHIFT_FPW2;
            end
            `SLLS_F_FOUR: begin
                fpw = `SLLS_FPW_ONE;
                fpw_shift = `SLLS_SHIFT_FPW1;
            end
            default: begin
                fpw = `SLLS_FPW_NONE;
                fpw_shift = `SLLS_SHIFT_FPW1;
            end
        endcase
    end
    assign k_val = k_is_32_i ? `SLLS_K_LONG : `SLLS_K_SHORT;
    assign wpm = k_val >> fpw_shift; // R12 R10
    // Subclass 1 setting counts frames, subclass 0 counts words
    assign release_word = subclass_i ? (multiframe_delay_i >> fpw_shift) : multiframe_delay_i; // R17 R18
    assign cfg_bad = (fpw == `SLLS_FPW_NONE)
                     || (!k_is_32_i && fpw == `SLLS_FPW_FOUR) // R12
                     || (multiframe_variation_i > `SLLS_MAX_VARIATION) // R16
                     || ({1'b0, release_word} >= wpm);
    assign frames_per_word_factor_o = fpw;
    assign words_per_multiframe_o = wpm;
    assign config_error_o = cfg_bad;

    // Multiframe counter: SYSREF edge restarts it in subclass 1 only
    assign sysref_edge = sysref_i && !sysref_prev_reg;
    always_comb begin
        sysref_prev_next = sysref_i;
        if (subclass_i && sysref_edge) begin // R07
            lmfc_cnt_next = 5'h00;
        end else if ({1'b0, lmfc_cnt_reg} >= wpm - 6'h01) begin // R08
            lmfc_cnt_next = 5'h00;
        end else begin
            lmfc_cnt_next = lmfc_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lmfc_cnt_reg <= 5'h00;
            sysref_prev_reg <= 1'b0;
        end else begin
            lmfc_cnt_reg <= lmfc_cnt_next;
            sysref_prev_reg <= sysref_prev_next;
        end
    end
    assign lmfc_boundary_o = (lmfc_cnt_reg == 5'h00);
    assign at_release = (lmfc_cnt_reg == release_word); // R13

    // Upper half of the lanes form the second link in dual mode
    for (genvar i = 0; i < NUM_LANES; i++) begin : g_active
        assign lane_active[i] = lane_enable_i[i]
                                && !link_reset_i[(two_link_select_i && i >= NUM_LANES / 2) ? 1 : 0]; // R20
    end

    assign all_arrived = ((lane_has_data & lane_active) == lane_active) && (lane_active != '0); // R09
    assign any_over = |(lane_over & lane_active);
    assign run_en = (state_reg == slls_pkg::SLLS_ALIGN_RUN);
    assign aligned_o = run_en;

    // Alignment state; one release event for every lane
    always_comb begin
        state_next = state_reg;
        window_err_next = window_err_reg;
        case (state_reg)
            slls_pkg::SLLS_ALIGN_IDLE: begin
                if (!cfg_bad && lane_active != '0) begin
                    state_next = slls_pkg::SLLS_ALIGN_WAIT;
                end
            end
            slls_pkg::SLLS_ALIGN_WAIT: begin
                if (cfg_bad) begin
                    state_next = slls_pkg::SLLS_ALIGN_IDLE;
                end else if (at_release && all_arrived) begin // R21 R13
                    state_next = slls_pkg::SLLS_ALIGN_RUN;
                end
                if (any_over) begin // R16
                    window_err_next = 1'b1;
                end
            end
            slls_pkg::SLLS_ALIGN_RUN: begin
                // Any active lane running empty breaks the common release point
                if (cfg_bad || !all_arrived) begin
                    state_next = slls_pkg::SLLS_ALIGN_IDLE;
                end
            end
            default: state_next = slls_pkg::SLLS_ALIGN_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= slls_pkg::SLLS_ALIGN_IDLE;
            window_err_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            window_err_reg <= window_err_next;
        end
    end
    assign window_error_o = window_err_reg;

    // Per-lane elastic buffer; early lanes wait here up to the variation window
    for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
        logic [DATA_W-1:0] mem_reg [BUF_DEPTH];
        logic [DATA_W-1:0] mem_next [BUF_DEPTH];
        logic [PW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next, fill;
        logic [DATA_W-1:0] dout_reg, dout_next;
        logic vout_reg, vout_next, wr_en, rd_en;

        assign fill = wr_ptr_reg - rd_ptr_reg;
        assign lane_has_data[i] = (fill != '0);
        assign lane_over[i] = (fill > {{(PW - 3){1'b0}}, multiframe_variation_i}); // R16
        assign lane_ready_o[i] = lane_active[i] && (fill != (PW + 1)'(BUF_DEPTH));
        assign wr_en = lane_valid_i[i] && lane_ready_o[i];
        assign rd_en = run_en && lane_active[i] && lane_has_data[i]; // R21

        always_comb begin
            mem_next = mem_reg;
            wr_ptr_next = wr_ptr_reg;
            rd_ptr_next = rd_ptr_reg;
            dout_next = dout_reg;
            vout_next = rd_en;
            if (!lane_active[i]) begin
                wr_ptr_next = '0;
                rd_ptr_next = '0;
            end else begin
                if (wr_en) begin
                    mem_next[wr_ptr_reg[PW-1:0]] = lane_data_i[i*DATA_W +: DATA_W];
                    wr_ptr_next = wr_ptr_reg + 1'b1;
                end
                if (rd_en) begin
                    dout_next = mem_reg[rd_ptr_reg[PW-1:0]];
                    rd_ptr_next = rd_ptr_reg + 1'b1;
                end
            end
        end

        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                for (int j = 0; j < BUF_DEPTH; j++) begin
                    mem_reg[j] <= '0;
                end
                wr_ptr_reg <= '0;
                rd_ptr_reg <= '0;
                dout_reg <= '0;
                vout_reg <= 1'b0;
            end else begin
                mem_reg <= mem_next;
                wr_ptr_reg <= wr_ptr_next;
                rd_ptr_reg <= rd_ptr_next;
                dout_reg <= dout_next;
                vout_reg <= vout_next;
            end
        end

        assign lane_data_o[i*DATA_W +: DATA_W] = dout_reg;
        assign lane_out_valid_o[i] = vout_reg;
    end

endmodule

// file: design/slls_params.svh
/*
 * Offsets, field positions, reset values and fixed counts of the
 * link latency setup block. Included by the block's design files only.
 */
`ifndef SLLS_PARAMS_SVH
`define SLLS_PARAMS_SVH

`define SLLS_REG_DUAL_B_CLOCK_POWER 12'h080
`define SLLS_REG_DUAL_B_RESET 8'h00
`define SLLS_GATE_MSB 7
`define SLLS_GATE_LSB 6
`define SLLS_GATE_ON 2'h1
`define SLLS_GATE_OFF 2'h0
`define SLLS_DUAL_B_DOWN 2'h3
`define SLLS_MAX_VARIATION 4'hA
`define SLLS_K_LONG 6'h20
`define SLLS_K_SHORT 6'h10
`define SLLS_F_ONE 3'h1
`define SLLS_F_TWO 3'h2
`define SLLS_F_FOUR 3'h4
`define SLLS_SHIFT_FPW4 2'h2
`define SLLS_SHIFT_FPW2 2'h1
`define SLLS_SHIFT_FPW1 2'h0
`define SLLS_FPW_FOUR 3'h4
`define SLLS_FPW_TWO 3'h2
`define SLLS_FPW_ONE 3'h1
`define SLLS_FPW_NONE 3'h0

`endif

// file: design/slls_pkg.sv
/*
 * Types shared by the link latency setup block.
 * Assumes slls_params.svh supplies the numeric constants.
 */
package slls_pkg;

    typedef enum logic [1:0] {
        SLLS_CDR_OVERSAMPLE = 2'h0,
        SLLS_CDR_FULL_RATE = 2'h1,
        SLLS_CDR_HALF_RATE = 2'h3,
        SLLS_CDR_INVALID = 2'h2
    } slls_cdr_mode_t;

    // Gray sequence along idle, wait, run
    typedef enum logic [1:0] {
        SLLS_ALIGN_IDLE = 2'h0,
        SLLS_ALIGN_WAIT = 2'h1,
        SLLS_ALIGN_RUN = 2'h3
    } slls_align_state_t;

endpackage

// file: verif/slls_assertions.sv
/*
 * Port-level concurrent checks for the link latency setup block.
 * Assumes it is bound into slls_top and shares its word clock and reset.
 */
module slls_assertions #(
    parameter int NUM_LANES = 8
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Inputs watched
    input wire logic [11:0] reg_addr_i,
    input wire logic [3:0] converter_powerdown_mask_i,
    input wire logic iq_route_swap_i,
    input wire logic two_link_select_i,
    input wire logic half_rate_i,
    input wire logic cdr_oversample_i,
    input wire logic [1:0] serdes_pll_divider_i,
    input wire logic subclass_i,
    input wire logic [2:0] octets_per_frame_i,
    input wire logic k_is_32_i,
    input wire logic [3:0] multiframe_variation_i,
    input wire logic sysref_i,
    // Outputs watched
    input wire logic [7:0] reg_rdata_o,
    input wire logic dual_b_clock_gate_o,
    input wire logic route_dual_b_to_out3_o,
    input wire slls_pkg::slls_cdr_mode_t cdr_mode_o,
    input wire logic [NUM_LANES-1:0] lane_out_valid_o,
    input wire logic lmfc_boundary_o,
    input wire logic config_error_o,
    input wire logic aligned_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cdr_code;
    assign cdr_code = {half_rate_i, cdr_oversample_i, serdes_pll_divider_i};
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    gate_rule_a: assert property (reg_addr_i == 12'h080 |-> dual_b_clock_gate_o ==
        (reg_rdata_o[7:6] == 2'h1 && converter_powerdown_mask_i[3:2] == 2'h3)) else $error("clock gate wrong");
    swap_route_a: assert property (route_dual_b_to_out3_o == (iq_route_swap_i && two_link_select_i))
        else $error("route swap wrong");
    cdr_decode_a: assert property (cdr_mode_o == (cdr_code == 4'h6 ? slls_pkg::SLLS_CDR_OVERSAMPLE :
        cdr_code == 4'h1 ? slls_pkg::SLLS_CDR_FULL_RATE : cdr_code == 4'h8 ? slls_pkg::SLLS_CDR_HALF_RATE :
        slls_pkg::SLLS_CDR_INVALID)) else $error("cdr mode wrong");
    k16_refuse_a: assert property (!k_is_32_i && octets_per_frame_i == 3'h1 |-> config_error_o)
        else $error("short K not refused");
    var_limit_a: assert property (multiframe_variation_i > 4'hA |-> config_error_o)
        else $error("variation not refused");
    sysref_align_a: assert property (subclass_i && $rose(sysref_i) |=> lmfc_boundary_o)
        else $error("sysref did not align");
    out_after_run_a: assert property (|lane_out_valid_o |-> $past(aligned_o))
        else $error("output outside release");
    bad_cfg_stop_a: assert property (config_error_o |=> !aligned_o)
        else $error("release with bad setup");
endmodule

bind slls_top slls_assertions #(.NUM_LANES(NUM_LANES)) slls_assertions_i (.*);

// file: verif/slls_lane_source.sv
/*
 * Behavioural serial transmitter: one word per lane per clock.
 * Assumes the block's ready is sampled on the rising clock edge.
 */
module slls_lane_source #(
    parameter int N = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Control
    input wire logic run_i,
    input wire logic [3:0] lag_i,
    // Lane handshake
    input wire logic [N-1:0] ready_i,
    output logic [N-1:0] valid_o,
    output logic [N*32-1:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] age;
    logic [15:0] seq [N];
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            age <= 8'h00;
            for (int i = 0; i < N; i++) seq[i] <= 16'h0000;
        end else if (run_i) begin
            age <= (age == 8'hFF) ? age : age + 8'h01;
            for (int i = 0; i < N; i++) seq[i] <= seq[i] + 16'(valid_o[i] && ready_i[i]);
        end
    end
    // Skew stays well inside one multiframe; word held until taken
    always_comb begin
        for (int i = 0; i < N; i++) begin
            valid_o[i] = run_i && age >= 8'(i * lag_i);
            data_o[i*32+:32] = valid_o[i] ? {16'(i), seq[i]} : ~{16'(i), seq[i] - 16'h0001};
        end
    end
endmodule

// file: verif/testbench.sv
/*
 * Self-checking bench for the link latency setup block.
 * Assumes a 100 MHz word clock and the lane source model on the lanes.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MIN_D = 4;
    localparam int MAX_D = 6;
    localparam logic [3:0] PD_TBL [5] = '{4'h7, 4'h6, 4'h3, 4'h0, 4'h0};
    localparam logic [4:0] DL_TBL = 5'b01010;
    localparam logic [15:0] CDR_IN = 16'h0816;
    localparam slls_pkg::slls_cdr_mode_t CDR_EXP [4] = '{slls_pkg::SLLS_CDR_OVERSAMPLE,
        slls_pkg::SLLS_CDR_FULL_RATE, slls_pkg::SLLS_CDR_HALF_RATE, slls_pkg::SLLS_CDR_INVALID};
    logic clk_sys_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, iq_route_swap_i = 1'b0, run = 1'b0;
    logic two_link_select_i = 1'b0, half_rate_i = 1'b0, cdr_oversample_i = 1'b0, equalizer_mode_i = 1'b0;
    logic subclass_i = 1'b0, k_is_32_i = 1'b1, sysref_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
    logic [3:0] converter_powerdown_mask_i = 4'h0, multiframe_variation_i = 4'(MAX_D + 1 - (MIN_D - 1));
    logic [1:0] serdes_pll_divider_i = 2'h1, link_reset_i = 2'h0, lane_enable_i = 2'h3;
    logic [2:0] octets_per_frame_i = 3'h1, frames_per_word_factor_o;
    logic [4:0] multiframe_delay_i = 5'((MIN_D - 1) % 8);
    logic [1:0] lane_valid_i, lane_ready_o, lane_out_valid_o;
    logic [63:0] lane_data_i, lane_data_o;
    logic [3:0] converter_powerdown_o;
    logic dual_b_clock_gate_o, route_dual_b_to_out3_o, equalizer_low_power_o, lmfc_boundary_o;
    logic config_error_o, window_error_o, aligned_o;
    slls_pkg::slls_cdr_mode_t cdr_mode_o;
    logic [5:0] words_per_multiframe_o;
    int num_errors = 0;
    int compares = 0;
    int bsince = 0;

    slls_top #(.NUM_LANES(2), .DATA_W(32), .BUF_DEPTH(16)) slls_top_i (.*);
    slls_lane_source #(.N(2)) slls_lane_source_i (.clk_i(clk_sys_i), .resetn_i(resetn_i), .run_i(run),
        .lag_i(4'h2), .ready_i(lane_ready_o), .valid_o(lane_valid_i), .data_o(lane_data_i));

    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) bsince <= lmfc_boundary_o ? 0 : bsince + 1;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic step();
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic do_reset();
        resetn_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
    endtask
    task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic reg_read(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        #1;
        check(reg_rdata_o, e);
    endtask
    task automatic set_cfg(input logic [2:0] f, input logic k, input logic [3:0] v);
        @(posedge clk_sys_i);
        octets_per_frame_i <= f;
        k_is_32_i <= k;
        multiframe_variation_i <= v;
        #1;
    endtask
    // Release word is counted from the boundary; first two words per lane in order
    task automatic align_check(input int rel);
        for (int n = 0; n < 100 && aligned_o !== 1'b1; n++) step();
        check(aligned_o, 1'b1);
        check(bsince, rel);
        step();
        check(lane_out_valid_o, 2'h3);
        check(lane_data_o, 64'h0001_0000_0000_0000);
        step();
        check(lane_data_o, 64'h0001_0001_0000_0001);
    endtask

    initial begin
        #100_000;
        num_errors++;
        complete_run();
    end

    initial begin
        do_reset();
        reg_read(12'h080, 8'h00);
        @(posedge clk_sys_i);
        converter_powerdown_mask_i <= 4'hC;
        reg_write(12'h080, 8'h40);
        reg_read(12'h080, 8'h40);
        check(dual_b_clock_gate_o, 1'b1);
        reg_write(12'h081, 8'hFF);
        reg_read(12'h081, 8'h00);
        reg_read(12'h080, 8'h40);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys_i);
            converter_powerdown_mask_i <= PD_TBL[i];
            two_link_select_i <= DL_TBL[i];
            iq_route_swap_i <= (i == 1);
            equalizer_mode_i <= i[0];
            #1;
            check(converter_powerdown_o, PD_TBL[i]);
            check({route_dual_b_to_out3_o, dual_b_clock_gate_o}, {i == 1, 1'b0});
            check(equalizer_low_power_o, i[0]);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_i);
            {half_rate_i, cdr_oversample_i, serdes_pll_divider_i} <= CDR_IN[i*4+:4];
            #1;
            check(cdr_mode_o, CDR_EXP[i]);
        end
        for (int i = 0; i < 3; i++) begin
            set_cfg(3'(1 << i), 1'b1, 4'h4);
            check({frames_per_word_factor_o, words_per_multiframe_o}, {3'(4 >> i), 6'(8 << i)});
            check(config_error_o, 1'b0);
        end
        set_cfg(3'h3, 1'b1, 4'h4);
        check({frames_per_word_factor_o, config_error_o}, {3'h0, 1'b1});
        set_cfg(3'h1, 1'b0, 4'h4);
        check(config_error_o, 1'b1);
        set_cfg(3'h2, 1'b0, 4'hA);
        check({words_per_multiframe_o, config_error_o}, {6'h08, 1'b0});
        set_cfg(3'h2, 1'b0, 4'hB);
        check(config_error_o, 1'b1);
        set_cfg(3'h1, 1'b1, 4'(MAX_D + 1 - (MIN_D - 1)));
        run <= 1'b1;
        align_check((MIN_D - 1) % 8);
        @(posedge clk_sys_i);
        two_link_select_i <= 1'b1;
        link_reset_i <= 2'h2;
        step();
        check(lane_ready_o[1], 1'b0);
        @(posedge clk_sys_i);
        run <= 1'b0;
        two_link_select_i <= 1'b0;
        link_reset_i <= 2'h0;
        subclass_i <= 1'b1;
        octets_per_frame_i <= 3'h2;
        multiframe_delay_i <= 5'(((MIN_D - 1) * 2) % 32);
        do_reset();
        @(posedge clk_sys_i);
        sysref_i <= 1'b1;
        @(posedge clk_sys_i);
        sysref_i <= 1'b0;
        run <= 1'b1;
        align_check((((MIN_D - 1) * 2) % 32) / 2);
        check(window_error_o, 1'b0);
        complete_run();
    end
endmodule
